// ==== i2chs_sequencer.sv ====
//
// Contract
// - Start request with both lines high reloads and starts the baud generator.
// - Lines still high at timeout: drive SDA low, set start-seen.
// - One period later clear start request, stop generator, hold SDA, event.
// - Lines low at start, or SCL low before SDA falls: collision, idle.
// - Idle restart pulls SCL low, then loads generator and frees SDA.
// - Restart: free SCL, both high one period, SDA low, SCL low.
// - Restart sets start-seen as SDA is driven low, event flag only after timeout.
// - Restart request during any other activity is ignored.
// - Restart collision: SDA low as SCL rises, or SCL falls early.
// - Buffer write in host mode sets buffer-full and starts shifting.
// - Bits change in the same cycle SCL falls; SCL low one period, high one period.
// - After eighth clock clear buffer-full and release SDA for acknowledge.
// - Ninth clock acknowledge goes to ack status: 0 acked, 1 not.
// - After ninth clock set event, stop generator, SCL low, SDA unchanged.
// - Address byte is seven bits plus read/write, all eight shifted.
// - Buffer write during transmit sets write collision, buffer kept.
// - Receive request ignored unless the sequencer is idle.
// - Receiving toggles SCL each rollover and shifts SDA in.
// - After eighth fall: clear request, load buffer, full, event, hold SCL.
// - Buffer read clears buffer-full; acknowledge may follow.
// - Released SCL stops generator until sampled high, then reloads.
// - Ack sequence: value on SDA, SCL low, high, low, request clears.
// - Buffer write during any sequence sets write collision.
`timescale 1ns/1ps
`default_nettype none
`include "i2chs_defines.svh"

module i2chs_sequencer #(
  parameter int BRG_W = `I2CHS_BRG_W
) (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic                     enable,
  input  wire logic [BRG_W-1:0]         baud_reload,
  input  wire i2chs_pkg::i2chs_cmd_t    cmd,
  input  wire logic [`I2CHS_BYTE_W-1:0] buf_wdata,
  output logic [`I2CHS_BYTE_W-1:0]      buf_rdata,
  output i2chs_pkg::i2chs_status_t      status,
  output logic                          busy,
  input  wire logic                     scl_i,
  output logic                          scl_o,
  output logic                          scl_oe,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe
);
  import i2chs_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (BRG_W < 2 || BRG_W > 16) begin : g_bad_brg_w
    $error("BRG_W must lie between 2 and 16");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    i2chs_state_t            state;
    logic [BRG_W-1:0]        cnt;
    logic                    run;
    logic [`I2CHS_BCNT_W-1:0] bitn;
    logic [`I2CHS_BYTE_W-1:0] shreg;
    logic [`I2CHS_BYTE_W-1:0] xfer_buf;
    logic                    scl_drv;
    logic                    sda_drv;
    logic                    scl_m;
    logic                    scl_s;
    logic                    sda_m;
    logic                    sda_s;
    i2chs_status_t           st;
  } i2chs_regs_t;

  localparam i2chs_regs_t RESET_VAL = '{
    state:    I2CHS_IDLE,
    cnt:      '0,
    run:      1'b0,
    bitn:     `I2CHS_BCNT_RST,
    shreg:    `I2CHS_BYTE_RST,
    xfer_buf: `I2CHS_BYTE_RST,
    scl_drv:  1'b0,
    sda_drv:  1'b0,
    scl_m:    1'b1,
    scl_s:    1'b1,
    sda_m:    1'b1,
    sda_s:    1'b1,
    st:       '0
  };

  i2chs_regs_t r_r;
  i2chs_regs_t r_nxt;

  logic scl_hi;
  logic sda_hi;
  logic tmo;

  assign scl_hi = r_r.scl_s;
  assign sda_hi = r_r.sda_s;
  assign tmo    = r_r.run && (r_r.cnt == '0);

  // High phases that wait on a released SCL
  function automatic logic high_phase(input i2chs_state_t s);
    return (s == I2CHS_TX_HIGH) || (s == I2CHS_RX_HIGH) ||
           (s == I2CHS_AK_HIGH);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_nxt = r_r;
    r_nxt.scl_m = scl_i;
    r_nxt.scl_s = r_r.scl_m;
    r_nxt.sda_m = sda_i;
    r_nxt.sda_s = r_r.sda_m;

    // Baud generator count-down
    if (r_r.run && !tmo) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end

    // Software clears first so that a same-cycle hardware set wins
    if (cmd.clr_port_event) begin
      r_nxt.st.port_event_flag = 1'b0;
    end
    if (cmd.clr_bus_collision) begin
      r_nxt.st.bus_collision_flag = 1'b0;
    end
    if (cmd.clr_write_collision) begin
      r_nxt.st.write_collision = 1'b0;
    end
    if (cmd.buf_read && r_r.state != I2CHS_TX_LOW &&
        r_r.state != I2CHS_TX_HIGH) begin
      r_nxt.st.buffer_full = 1'b0;
    end

    // Clock stretching: count only once SCL is seen high
    if (high_phase(r_r.state) && !r_r.run && scl_hi) begin
      r_nxt.cnt = baud_reload;
      r_nxt.run = 1'b1;
    end

    // Buffer writes outside idle are refused
    if (cmd.buf_write && r_r.state != I2CHS_IDLE) begin
      r_nxt.st.write_collision = 1'b1;
    end

    unique case (r_r.state)
      I2CHS_IDLE: begin
        if (cmd.start_request) begin
          if (scl_hi && sda_hi) begin
            r_nxt.st.start_request = 1'b1;
            r_nxt.cnt   = baud_reload;
            r_nxt.run   = 1'b1;
            r_nxt.state = I2CHS_ST_WAIT;
          end else begin
            r_nxt.st.bus_collision_flag = 1'b1;
          end
        end else if (cmd.restart_request) begin
          r_nxt.st.restart_request = 1'b1;
          r_nxt.scl_drv = 1'b1;
          r_nxt.state   = I2CHS_RS_LOW;
        end else if (cmd.receive_request) begin
          r_nxt.st.receive_request = 1'b1;
          r_nxt.sda_drv = 1'b0;
          r_nxt.scl_drv = 1'b1;
          r_nxt.bitn    = `I2CHS_BCNT_RST;
          r_nxt.cnt     = baud_reload;
          r_nxt.run     = 1'b1;
          r_nxt.state   = I2CHS_RX_LOW;
        end else if (cmd.ack_sequence_request) begin
          r_nxt.st.ack_sequence_request = 1'b1;
          r_nxt.sda_drv = !cmd.ack_value_select;
          r_nxt.scl_drv = 1'b1;
          r_nxt.cnt     = baud_reload;
          r_nxt.run     = 1'b1;
          r_nxt.state   = I2CHS_AK_LOW;
        end else if (cmd.buf_write) begin
          r_nxt.xfer_buf = buf_wdata;
          r_nxt.shreg    = buf_wdata;
          r_nxt.st.buffer_full = 1'b1;
          r_nxt.sda_drv  = !buf_wdata[`I2CHS_MSB];
          r_nxt.scl_drv  = 1'b1;
          r_nxt.bitn     = `I2CHS_BCNT_RST;
          r_nxt.cnt      = baud_reload;
          r_nxt.run      = 1'b1;
          r_nxt.state    = I2CHS_TX_LOW;
        end
      end

      I2CHS_ST_WAIT: begin
        if (!scl_hi) begin
          r_nxt.st.bus_collision_flag = 1'b1;
          r_nxt.st.start_request = 1'b0;
          r_nxt.run   = 1'b0;
          r_nxt.state = I2CHS_IDLE;
        end else if (tmo) begin
          if (sda_hi) begin
            r_nxt.sda_drv = 1'b1;
            r_nxt.st.start_seen = 1'b1;
            r_nxt.cnt   = baud_reload;
            r_nxt.state = I2CHS_ST_HOLD;
          end else begin
            r_nxt.st.bus_collision_flag = 1'b1;
            r_nxt.st.start_request = 1'b0;
            r_nxt.run   = 1'b0;
            r_nxt.state = I2CHS_IDLE;
          end
        end
      end

      I2CHS_ST_HOLD: begin
        if (tmo) begin
          r_nxt.st.start_request   = 1'b0;
          r_nxt.st.port_event_flag = 1'b1;
          r_nxt.run   = 1'b0;
          r_nxt.state = I2CHS_IDLE;
        end
      end

      I2CHS_RS_LOW: begin
        if (!scl_hi) begin
          r_nxt.sda_drv = 1'b0;
          r_nxt.cnt     = baud_reload;
          r_nxt.run     = 1'b1;
          r_nxt.state   = I2CHS_RS_SDA;
        end
      end

      I2CHS_RS_SDA: begin
        // Freed SDA reaches the synchroniser two clocks late, so a short
        // period waits for it; a stuck SDA holds here until disable
        if (tmo) begin
          r_nxt.run = 1'b0;
        end
        if ((tmo || !r_r.run) && sda_hi) begin
          r_nxt.scl_drv = 1'b0;
          r_nxt.state   = I2CHS_RS_REL;
        end
      end

      I2CHS_RS_REL: begin
        if (scl_hi) begin
          if (sda_hi) begin
            r_nxt.cnt   = baud_reload;
            r_nxt.run   = 1'b1;
            r_nxt.state = I2CHS_RS_HI;
          end else begin
            r_nxt.st.bus_collision_flag = 1'b1;
            r_nxt.st.restart_request = 1'b0;
            r_nxt.state = I2CHS_IDLE;
          end
        end
      end

      I2CHS_RS_HI: begin
        if (!scl_hi) begin
          r_nxt.st.bus_collision_flag = 1'b1;
          r_nxt.st.restart_request = 1'b0;
          r_nxt.run   = 1'b0;
          r_nxt.state = I2CHS_IDLE;
        end else if (tmo) begin
          r_nxt.sda_drv = 1'b1;
          r_nxt.st.start_seen = 1'b1;
          r_nxt.cnt   = baud_reload;
          r_nxt.state = I2CHS_RS_SDL;
        end
      end

      I2CHS_RS_SDL: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b1;
          r_nxt.st.restart_request = 1'b0;
          r_nxt.st.port_event_flag = 1'b1;
          r_nxt.run   = 1'b0;
          r_nxt.state = I2CHS_IDLE;
        end
      end

      I2CHS_TX_LOW: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b0;
          r_nxt.run     = 1'b0;
          r_nxt.state   = I2CHS_TX_HIGH;
        end
      end

      I2CHS_TX_HIGH: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b1;
          if (r_r.bitn == `I2CHS_TX_ACK_BIT) begin
            r_nxt.st.ack_received_status = sda_hi;
            r_nxt.st.port_event_flag = 1'b1;
            r_nxt.run   = 1'b0;
            r_nxt.state = I2CHS_IDLE;
          end else begin
            r_nxt.bitn  = r_r.bitn + `I2CHS_BCNT_ONE;
            r_nxt.shreg = {r_r.shreg[`I2CHS_MSB-1:0], 1'b0};
            if (r_r.bitn == `I2CHS_RX_LAST_BIT) begin
              r_nxt.st.buffer_full = 1'b0;
              r_nxt.sda_drv = 1'b0;
            end else begin
              r_nxt.sda_drv = !r_r.shreg[`I2CHS_MSB-1];
            end
            r_nxt.cnt   = baud_reload;
            r_nxt.state = I2CHS_TX_LOW;
          end
        end
      end

      I2CHS_RX_LOW: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b0;
          r_nxt.run     = 1'b0;
          r_nxt.state   = I2CHS_RX_HIGH;
        end
      end

      I2CHS_RX_HIGH: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b1;
          r_nxt.shreg = {r_r.shreg[`I2CHS_MSB-1:0], sda_hi};
          r_nxt.bitn  = r_r.bitn + `I2CHS_BCNT_ONE;
          if (r_r.bitn == `I2CHS_RX_LAST_BIT) begin
            r_nxt.st.receive_request = 1'b0;
            r_nxt.xfer_buf = {r_r.shreg[`I2CHS_MSB-1:0], sda_hi};
            r_nxt.st.buffer_full     = 1'b1;
            r_nxt.st.port_event_flag = 1'b1;
            r_nxt.run   = 1'b0;
            r_nxt.state = I2CHS_IDLE;
          end else begin
            r_nxt.cnt   = baud_reload;
            r_nxt.state = I2CHS_RX_LOW;
          end
        end
      end

      I2CHS_AK_LOW: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b0;
          r_nxt.run     = 1'b0;
          r_nxt.state   = I2CHS_AK_HIGH;
        end
      end

      I2CHS_AK_HIGH: begin
        if (tmo) begin
          r_nxt.scl_drv = 1'b1;
          r_nxt.st.ack_sequence_request = 1'b0;
          r_nxt.st.port_event_flag = 1'b1;
          r_nxt.run   = 1'b0;
          r_nxt.state = I2CHS_IDLE;
        end
      end

      default: begin
        r_nxt.state = I2CHS_IDLE;
      end
    endcase

    // Disable wins over everything, keeps pin samples fresh
    if (!enable) begin
      r_nxt       = RESET_VAL;
      r_nxt.scl_m = scl_i;
      r_nxt.scl_s = r_r.scl_m;
      r_nxt.sda_m = sda_i;
      r_nxt.sda_s = r_r.sda_m;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_r <= RESET_VAL;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Open-drain: only ever pull low
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = r_r.scl_drv;
  assign sda_oe    = r_r.sda_drv;
  assign buf_rdata = r_r.xfer_buf;
  assign status    = r_r.st;
  assign busy      = (r_r.state != I2CHS_IDLE);

endmodule
`default_nettype wire

// ==== i2chs_defines.svh ====
`ifndef I2CHS_DEFINES_SVH
`define I2CHS_DEFINES_SVH

// Baud generator width and reload reset value
`define I2CHS_BRG_W        8
`define I2CHS_BRG_RST      8'h00

// Byte and bit counting
`define I2CHS_BYTE_W       8
`define I2CHS_BYTE_RST     8'h00
`define I2CHS_MSB          7
`define I2CHS_BCNT_W       4
`define I2CHS_BCNT_RST     4'h0
`define I2CHS_BCNT_ONE     4'h1
`define I2CHS_TX_ACK_BIT   4'h8
`define I2CHS_RX_LAST_BIT  4'h7

`endif

// ==== i2chs_pkg.sv ====
`include "i2chs_defines.svh"

package i2chs_pkg;

  typedef enum logic [3:0] {
    I2CHS_IDLE    = 4'h0,
    I2CHS_ST_WAIT = 4'h1,
    I2CHS_ST_HOLD = 4'h2,
    I2CHS_RS_LOW  = 4'h3,
    I2CHS_RS_SDA  = 4'h4,
    I2CHS_RS_REL  = 4'h5,
    I2CHS_RS_HI   = 4'h6,
    I2CHS_RS_SDL  = 4'h7,
    I2CHS_TX_LOW  = 4'h8,
    I2CHS_TX_HIGH = 4'h9,
    I2CHS_RX_LOW  = 4'hA,
    I2CHS_RX_HIGH = 4'hB,
    I2CHS_AK_LOW  = 4'hC,
    I2CHS_AK_HIGH = 4'hD
  } i2chs_state_t;

  // Software commands, each a one-cycle pulse except ack_value_select
  typedef struct packed {
    logic start_request;
    logic restart_request;
    logic receive_request;
    logic ack_sequence_request;
    logic ack_value_select;
    logic buf_write;
    logic buf_read;
    logic clr_port_event;
    logic clr_bus_collision;
    logic clr_write_collision;
  } i2chs_cmd_t;

  // Status seen by software, all from flip-flops
  typedef struct packed {
    logic start_request;
    logic restart_request;
    logic receive_request;
    logic ack_sequence_request;
    logic start_seen;
    logic buffer_full;
    logic write_collision;
    logic port_event_flag;
    logic bus_collision_flag;
    logic ack_received_status;
  } i2chs_status_t;

endpackage

// ==== i2chs_client_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************
// Two-wire client model
// ************************
module i2chs_client_model (
  input  wire logic       sys_clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       rd,
  input  wire logic       nack,
  input  wire logic       stretch,
  input  wire logic [7:0] rx_byte,
  output logic            scl_pull,
  output logic            sda_pull
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [3:0] cnt   = 4'hF;
  logic [2:0] st    = 3'h0;
  always @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    st    <= (st != 3'h0) ? st - 3'h1 : 3'h0;
    if (scl && sda_q && !sda) begin
      cnt <= 4'hF;
    end else if (scl_q && !scl) begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      st  <= stretch ? 3'h6 : 3'h0;
    end
  end
  // Stretch holds SCL low past the host's release
  assign scl_pull = (st != 3'h0);
  // Eight bits MSB first, then the ack slot
  assign sda_pull = rd ? (cnt < 4'h8 && !rx_byte[3'h7 - cnt[2:0]])
                       : (cnt == 4'h8 && !nack);
endmodule
`default_nettype wire

// ==== i2chs_sequencer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "i2chs_defines.svh"
module i2chs_sequencer_asserts #(
  parameter int BRG_W = `I2CHS_BRG_W
) (
  input wire logic                     sys_clk,
  input wire logic                     arst_n,
  input wire logic                     enable,
  input wire logic [BRG_W-1:0]         baud_reload,
  input wire i2chs_pkg::i2chs_cmd_t    cmd,
  input wire logic [`I2CHS_BYTE_W-1:0] buf_wdata,
  input wire logic [`I2CHS_BYTE_W-1:0] buf_rdata,
  input wire i2chs_pkg::i2chs_status_t status,
  input wire logic                     busy,
  input wire logic                     scl_i,
  input wire logic                     scl_o,
  input wire logic                     scl_oe,
  input wire logic                     sda_i,
  input wire logic                     sda_o,
  input wire logic                     sda_oe
);
  import i2chs_pkg::*;
  logic [BRG_W:0] n1;
  logic [BRG_W:0] low_cnt_r;
  logic [BRG_W:0] hold_cnt_r;
  assign n1 = baud_reload + 1'b1;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_r  <= '0;
      hold_cnt_r <= '0;
    end else begin
      low_cnt_r  <= (scl_oe && busy) ? low_cnt_r + 1'b1 : '0;
      hold_cnt_r <= (sda_oe && status.start_request) ? hold_cnt_r + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  property p_start_coll;
    (!scl_i && !sda_i) [*3] ##0 (cmd.start_request && !busy && enable)
      |-> ##[1:4] status.bus_collision_flag;
  endproperty
  a_start_coll: assert property (p_start_coll)
    else $error("start on low bus not flagged");
  property p_start_hold;
    $fell(status.start_request) && status.port_event_flag && enable &&
      !status.bus_collision_flag |-> hold_cnt_r == n1 && sda_oe && !busy;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start hold period wrong");
  property p_rs_busy;
    busy && cmd.restart_request && !status.restart_request
      |=> !status.restart_request;
  endproperty
  a_rs_busy: assert property (p_rs_busy)
    else $error("restart taken while busy");
  property p_rx_busy;
    busy && cmd.receive_request && !status.receive_request
      |=> !status.receive_request;
  endproperty
  a_rx_busy: assert property (p_rx_busy)
    else $error("receive taken while busy");
  property p_write_collision;
    busy && cmd.buf_write && !status.receive_request
      |=> status.write_collision && $stable(buf_rdata);
  endproperty
  a_write_collision: assert property (p_write_collision)
    else $error("write during sequence not refused");
  property p_ack_free;
    $fell(status.buffer_full) |-> !sda_oe;
  endproperty
  a_ack_free: assert property (p_ack_free)
    else $error("data line held in ack slot");
  property p_evt_hold;
    $rose(status.port_event_flag) && !$past(status.start_request)
      |-> scl_oe && !busy;
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("clock not held low at event");
  property p_stretch;
    busy && !scl_oe && !scl_i |=> !scl_oe;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("clock driven while stretched");
  property p_low_time;
    $fell(scl_oe) && busy && status.buffer_full |-> low_cnt_r == n1;
  endproperty
  a_low_time: assert property (p_low_time)
    else $error("clock low phase length wrong");
  c_start: cover property ($fell(status.start_request) && status.port_event_flag);
  c_coll: cover property ($rose(status.bus_collision_flag));
  c_rx: cover property ($fell(status.receive_request) && status.buffer_full);
endmodule
bind i2chs_sequencer i2chs_sequencer_asserts #(.BRG_W(BRG_W)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .enable(enable),
  .baud_reload(baud_reload), .cmd(cmd), .buf_wdata(buf_wdata),
  .buf_rdata(buf_rdata), .status(status), .busy(busy), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe)
);
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2chs_pkg::*;
  localparam i2chs_cmd_t C_ST = 10'h200;
  localparam i2chs_cmd_t C_RS = 10'h100;
  localparam i2chs_cmd_t C_RX = 10'h080;
  localparam i2chs_cmd_t C_AK = 10'h040;
  localparam i2chs_cmd_t C_AV = 10'h020;
  localparam i2chs_cmd_t C_WR = 10'h010;
  localparam i2chs_cmd_t C_RD = 10'h008;
  localparam i2chs_cmd_t C_CE = 10'h004;
  localparam i2chs_cmd_t C_CB = 10'h002;
  localparam i2chs_cmd_t C_CW = 10'h001;
  logic          sys_clk = 1'b0;
  logic          arst_n = 1'b0;
  logic          enable = 1'b1;
  logic [7:0]    baud_reload = 8'h01;
  i2chs_cmd_t    cmd = '0;
  logic [7:0]    buf_wdata = 8'h00;
  logic [7:0]    buf_rdata;
  i2chs_status_t status;
  logic          busy;
  logic          scl_oe;
  logic          sda_oe;
  logic          scl_o;
  logic          sda_o;
  logic          scl_pull;
  logic          sda_pull;
  logic          bus_lo = 1'b0;
  logic          rd = 1'b0;
  logic          nack = 1'b0;
  logic          stretch = 1'b0;
  logic [7:0]    rx_byte = 8'h00;
  logic [8:0]    mon = '0;
  logic [3:0]    nrise = '0;
  int            error_cnt = 0;
  int            num_checks = 0;
  int            cyc = 0;
  // Open-drain lines with pull-ups
  wire scl = !((scl_oe & !scl_o) | scl_pull | bus_lo);
  wire sda = !((sda_oe & !sda_o) | sda_pull | bus_lo);
  i2chs_sequencer uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .enable(enable),
    .baud_reload(baud_reload), .cmd(cmd), .buf_wdata(buf_wdata),
    .buf_rdata(buf_rdata), .status(status), .busy(busy), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe)
  );
  i2chs_client_model client (
    .sys_clk(sys_clk), .scl(scl), .sda(sda), .rd(rd), .nack(nack),
    .stretch(stretch), .rx_byte(rx_byte), .scl_pull(scl_pull),
    .sda_pull(sda_pull)
  );
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge scl) begin
    mon <= {mon[7:0], sda};
    nrise <= nrise + 4'h1;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Far above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input i2chs_cmd_t c);
    @(negedge sys_clk);
    cmd = c;
    @(negedge sys_clk);
    cmd = '0;
  endtask
  task automatic wait_evt();
    int n;
    n = 0;
    while (status.port_event_flag !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(n < 5000), 16'h1);
  endtask
  task automatic tx(input logic [7:0] d, input logic na);
    nack = na;
    stretch = 1'($urandom_range(0, 1));
    baud_reload = 8'($urandom_range(1, 4));
    mon = '0;
    nrise = '0;
    buf_wdata = d;
    pulse(C_WR);
    chk(status.buffer_full, 1'b1);
    buf_wdata = ~d;
    pulse(C_RS | C_RX | C_WR);
    chk({status.restart_request, status.receive_request,
         status.write_collision, buf_rdata}, {3'b001, d});
    pulse(C_CW);
    wait_evt();
    chk({nrise, mon}, {4'h9, d, na});
    chk({status.buffer_full, status.ack_received_status}, {1'b0, na});
    pulse(C_CE);
  endtask
  initial begin
    int i;
    logic ak;
    void'($urandom(61));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    buf_wdata = 8'hA5;
    pulse(C_ST);
    pulse(C_WR);
    chk({status.write_collision, buf_rdata}, 9'h100);
    wait_evt();
    chk({status.start_request, status.start_seen, sda_oe, scl_oe}, 4'h6);
    pulse(C_CW);
    pulse(C_CE);
    $display("test start done");
    for (i = 0; i < 4; i++) begin
      tx(8'($urandom), 1'($urandom_range(0, 1)));
    end
    $display("test transmit done");
    tx(8'hA1, 1'b0);
    rd = 1'b1;
    for (i = 0; i < 2; i++) begin
      rx_byte = 8'($urandom);
      mon = '0;
      nrise = '0;
      pulse(C_RX);
      wait_evt();
      chk({status.receive_request, status.buffer_full, buf_rdata},
          {2'b01, rx_byte});
      pulse(C_CE);
      pulse(C_RD);
      chk(status.buffer_full, 1'b0);
      ak = 1'($urandom_range(0, 1));
      pulse(ak ? (C_AK | C_AV) : C_AK);
      wait_evt();
      chk({status.ack_sequence_request, nrise, mon},
          {1'b0, 4'h9, rx_byte, ak});
      pulse(C_CE);
    end
    rd = 1'b0;
    $display("test receive done");
    mon = '0;
    nrise = '0;
    // Shortest period: freed SDA is seen only after the timeout
    baud_reload = 8'h01;
    pulse(C_RS);
    chk(status.restart_request, 1'b1);
    wait_evt();
    chk({status.restart_request, sda_oe, scl_oe, nrise}, 7'h31);
    pulse(C_CE);
    $display("test restart done");
    buf_wdata = 8'h3C;
    pulse(C_WR);
    repeat (7) @(negedge sys_clk);
    enable = 1'b0;
    @(negedge sys_clk);
    chk({busy, scl_oe, sda_oe, status}, 13'h0000);
    enable = 1'b1;
    bus_lo = 1'b1;
    repeat (4) @(negedge sys_clk);
    pulse(C_ST);
    repeat (4) @(negedge sys_clk);
    chk({status.bus_collision_flag, busy, scl_oe, sda_oe}, 4'h8);
    bus_lo = 1'b0;
    pulse(C_CB);
    chk(status.bus_collision_flag, 1'b0);
    $display("test collision done");
    test_done();
  end
endmodule
`default_nettype wire
